// ---- core/ddp_defines.vh ----
/*
 * ddp_defines.vh - constants for the dual-DAC parallel-port host controller.
 * Assumes: included by bare name from core/ design files; 125 MHz clock.
 */
`ifndef DDP_DEFINES_VH
`define DDP_DEFINES_VH

// --------------------------------------------------------------------------
// word and timing
// --------------------------------------------------------------------------
`define DDP_DATA_W        12
`define DDP_CLK_NS        8
// select low time, select high gap, bus setup before select falls (ns)
`define DDP_SEL_LOW_NS    40
`define DDP_SEL_HIGH_NS   40
`define DDP_SETUP_NS      16
// least times round up to whole cycles
`define DDP_SEL_LOW_CYC   ((`DDP_SEL_LOW_NS + `DDP_CLK_NS - 1) / `DDP_CLK_NS)
`define DDP_SEL_HIGH_CYC  ((`DDP_SEL_HIGH_NS + `DDP_CLK_NS - 1) / `DDP_CLK_NS)
`define DDP_SETUP_CYC     ((`DDP_SETUP_NS + `DDP_CLK_NS - 1) / `DDP_CLK_NS)
`define DDP_CNT_W         4

// --------------------------------------------------------------------------
// states
// --------------------------------------------------------------------------
`define DDP_ST_IDLE       3'h0
`define DDP_ST_SETUP      3'h1
`define DDP_ST_LOW        3'h2
`define DDP_ST_HIGH       3'h3
`define DDP_ST_W          3

`define DDP_CNT_ZERO      4'h0
`define DDP_CNT_ONE       4'h1
`define DDP_DATA_ZERO     12'h000

`endif

// ---- core/ddp_sync3.v ----
/*
 * ddp_sync3.v - three-flop input synchroniser with agreement filter.
 * Assumes: asynchronous input; output changes only when flops 2 and 3 agree.
 */
`timescale 1ns/1ps
`include "ddp_defines.vh"

module ddp_sync3 #(
    parameter W = 12
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // ddp_sync3

// ---- core/ddp_host.v ----
/*
 * ddp_host.v - host controller that drives a dual current-output DAC through
 * its select, direction, channel and data pins, one word per request.
 * Assumes: one 125 MHz clock; the DAC answers reads on the data pins while
 * select is low; the channel pin feeds the board address decoder.
 */
`timescale 1ns/1ps
`include "ddp_defines.vh"

module ddp_host (
    input  wire                   clock,
    input  wire                   rst,
    // request side
    input  wire                   req_valid,
    output wire                   req_ready,
    input  wire                   req_read,
    input  wire                   req_chan,
    input  wire [`DDP_DATA_W-1:0] req_data,
    output reg                    rsp_valid,
    output reg  [`DDP_DATA_W-1:0] rsp_data,
    output reg                    rsp_chan,
    // pins toward the DAC
    output reg                    sel_n,
    output reg                    rd_wr,
    output reg                    chan_b,
    output reg  [`DDP_DATA_W-1:0] db_o,
    output reg                    db_oe,
    input  wire [`DDP_DATA_W-1:0] db_i
);
    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    // states
    localparam [`DDP_ST_W-1:0] ST_IDLE  = `DDP_ST_IDLE;
    localparam [`DDP_ST_W-1:0] ST_SETUP = `DDP_ST_SETUP;
    localparam [`DDP_ST_W-1:0] ST_LOW   = `DDP_ST_LOW;
    localparam [`DDP_ST_W-1:0] ST_HIGH  = `DDP_ST_HIGH;

    // counts are worked out as integers, then cut to the counter width
    localparam integer SETUP_CYC_I = `DDP_SETUP_CYC;
    localparam integer LOW_CYC_I   = `DDP_SEL_LOW_CYC;
    localparam integer HIGH_CYC_I  = `DDP_SEL_HIGH_CYC;
    localparam [`DDP_CNT_W-1:0] SETUP_CNT = SETUP_CYC_I[`DDP_CNT_W-1:0];
    localparam [`DDP_CNT_W-1:0] LOW_CNT   = LOW_CYC_I[`DDP_CNT_W-1:0];
    localparam [`DDP_CNT_W-1:0] HIGH_CNT  = HIGH_CYC_I[`DDP_CNT_W-1:0];

    reg  [`DDP_ST_W-1:0]   st_q;
    reg  [`DDP_ST_W-1:0]   st_d;
    reg  [`DDP_CNT_W-1:0]  cnt_q;
    reg  [`DDP_CNT_W-1:0]  cnt_d;
    reg                    rd_q;
    reg                    rd_d;
    wire [`DDP_DATA_W-1:0] db_sync;
    wire [`DDP_CNT_W-1:0]  cnt_dec;
    wire                   take;
    wire                   cnt_last;
    wire                   setup_done;
    wire                   low_done;
    wire                   gap_done;
    wire                   bad_state;
    wire                   rd_done;

    // ----------------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------------
    assign req_ready  = (st_q == ST_IDLE);
    assign take       = req_valid && req_ready;
    assign cnt_dec    = cnt_q - `DDP_CNT_ONE;
    assign cnt_last   = (cnt_q == `DDP_CNT_ONE);
    assign setup_done = (st_q == ST_SETUP) && cnt_last;
    assign low_done   = (st_q == ST_LOW) && cnt_last;
    assign gap_done   = (st_q == ST_HIGH) && cnt_last;
    assign rd_done    = low_done && rd_q;
    // codes above the last state never occur unless an upset hits st_q
    assign bad_state  = (st_q > ST_HIGH);

    // readback pins come from outside the clock domain
    ddp_sync3 #(
        .W (`DDP_DATA_W)
    ) u_db_sync (
        .clock (clock),
        .rst   (rst),
        .d     (db_i),
        .q     (db_sync)
    );

    // ----------------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------------
    // one request walks setup, select low and select high; the high gap is
    // spent before ready returns, so back-to-back pulses never merge
    always @* begin
        st_d  = st_q;
        cnt_d = cnt_q;
        rd_d  = rd_q;
        case (st_q)
            ST_IDLE: begin
                if (req_valid) begin
                    rd_d  = req_read;
                    cnt_d = SETUP_CNT;
                    st_d  = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_last) begin
                    cnt_d = LOW_CNT;
                    st_d  = ST_LOW;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_LOW: begin
                if (cnt_last) begin
                    cnt_d = HIGH_CNT;
                    st_d  = ST_HIGH;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_HIGH: begin
                // guaranteed high gap keeps pulses apart
                if (cnt_last) begin
                    st_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            default: begin
                // illegal code: park in idle
                st_d  = ST_IDLE;
                cnt_d = `DDP_CNT_ZERO;
            end
        endcase
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q  <= ST_IDLE;
            cnt_q <= `DDP_CNT_ZERO;
            rd_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            rd_q  <= rd_d;
        end
    end

    // ----------------------------------------------------------------------
    // select pin
    // ----------------------------------------------------------------------
    // registered so the DAC never sees a glitch on its only strobe;
    // limitation: pulse timing is fixed at build time, not per request
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_n <= 1'b1;
        end else if (setup_done) begin
            sel_n <= 1'b0;
        end else if (low_done || bad_state) begin
            // rising edge completes the pulse; data stays driven
            // through it so the DAC latches a stable word
            sel_n <= 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // direction, channel and write data
    // ----------------------------------------------------------------------
    // direction, channel and data settle with select high and hold until
    // the gap ends; the bus is driven only for writes
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_wr  <= 1'b1;
            chan_b <= 1'b0;
            db_o   <= `DDP_DATA_ZERO;
            db_oe  <= 1'b0;
        end else if (take) begin
            rd_wr  <= req_read;
            chan_b <= req_chan;
            // all twelve bits move in one pulse, no packing of narrow words
            db_o   <= req_data;
            db_oe  <= ~req_read;
        end else if (gap_done) begin
            db_oe <= 1'b0;
            rd_wr <= 1'b1;
        end else if (bad_state) begin
            db_oe <= 1'b0;
        end
    end

    // ----------------------------------------------------------------------
    // readback capture
    // ----------------------------------------------------------------------
    // one-cycle pulse; data and channel hold until the next read
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= `DDP_DATA_ZERO;
            rsp_chan  <= 1'b0;
        end else begin
            rsp_valid <= rd_done;
            if (rd_done) begin
                // synchroniser lag is covered by the low time
                rsp_data <= db_sync;
                rsp_chan <= chan_b;
            end
        end
    end
endmodule // ddp_host

// ---- dv/ddp_checker.sv ----
/* ddp_checker.sv: pin-timing assertions for the host controller.
   assumes: bound to ddp_host; one clock, rst asynchronous active high. */
`timescale 1ns/1ps
`include "ddp_defines.vh"
module ddp_checker (
    input wire                   clock,
    input wire                   rst,
    input wire                   req_valid,
    input wire                   req_ready,
    input wire                   req_read,
    input wire                   req_chan,
    input wire [`DDP_DATA_W-1:0] req_data,
    input wire                   rsp_valid,
    input wire                   sel_n,
    input wire                   rd_wr,
    input wire                   chan_b,
    input wire [`DDP_DATA_W-1:0] db_o,
    input wire                   db_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence take_s; req_valid && req_ready; endsequence
    sequence pulse_s; $fell(sel_n) ##1 (!sel_n)[*4] ##1 sel_n; endsequence
    sel_pulse_a: assert property (take_s |-> ##3 pulse_s) else $error("bad select pulse");
    sel_gap_a: assert property ($rose(sel_n) |-> sel_n[*5]) else $error("select gap short");
    busy_hold_a: assert property (take_s |=> (!req_ready)[*8]) else $error("early ready");
    wr_hold_a: assert property ($fell(sel_n) && !rd_wr |-> ($stable(db_o) && db_oe && !rd_wr)[*6])
        else $error("write data moved");
    dir_first_a: assert property ($fell(sel_n) |-> $stable(rd_wr) && $stable(chan_b))
        else $error("direction late");
    req_map_a: assert property (take_s |=> chan_b == $past(req_chan) && rd_wr == $past(req_read))
        else $error("channel or direction wrong");
    wr_word_a: assert property ((take_s ##0 !req_read) |=> db_oe && db_o == $past(req_data))
        else $error("write word wrong");
    rd_release_a: assert property (rd_wr |-> !db_oe) else $error("bus driven in read");
    rsp_pulse_a: assert property (rsp_valid |-> ($rose(sel_n) && rd_wr) ##1 !rsp_valid)
        else $error("bad readback pulse");
endmodule // ddp_checker
bind ddp_host ddp_checker ddp_checker_i (.*);

// ---- dv/ddp_dac_model.sv ----
/* ddp_dac_model.sv: behavioural dual DAC on the select, direction and data pins.
   assumes: the bench feeds the host's data and enable in and uses db_line as the pins. */
`timescale 1ns/1ps
`include "ddp_defines.vh"
module ddp_dac_model (
    input  wire                   sel_n,
    input  wire                   rd_wr,
    input  wire                   chan_b,
    input  wire                   host_oe,
    input  wire [`DDP_DATA_W-1:0] host_d,
    output wire [`DDP_DATA_W-1:0] db_line
);
    reg [`DDP_DATA_W-1:0] dac_q [0:1];
    reg [`DDP_DATA_W-1:0] latch_q;
    initial begin
        dac_q[0] = 12'h000;
        dac_q[1] = 12'h000;
        latch_q = 12'h000;
    end
    // only select edges move data, so a held-low select loads nothing
    always @(posedge sel_n) if (!rd_wr) begin
        latch_q = host_d;
        dac_q[chan_b] = host_d;
    end
    always @(negedge sel_n) if (rd_wr) latch_q = dac_q[chan_b];
    // released pins show the inverse so stale data can never pass as a match
    assign db_line = host_oe ? host_d : (!sel_n && rd_wr) ? latch_q : ~latch_q;
endmodule // ddp_dac_model

// ---- dv/ddp_host_test.sv ----
/* ddp_host_test.sv: self-checking bench for the host controller.
   assumes: ddp_dac_model on the pins; 125 MHz clock. */
`timescale 1ns/1ps
`include "ddp_defines.vh"
module ddp_host_test;
    reg                    clock = 1'b0;
    reg                    rst = 1'b1;
    reg                    req_valid = 1'b0, req_read = 1'b0, req_chan = 1'b0;
    reg  [`DDP_DATA_W-1:0] req_data = 12'h000;
    wire                   req_ready, rsp_valid, rsp_chan, sel_n, rd_wr, chan_b, db_oe;
    wire [`DDP_DATA_W-1:0] rsp_data, db_o, db_w;
    integer                err_total = 0, checks_done = 0, cyc = 0;
    always #4 clock = ~clock;
    ddp_host ddp_host_i (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_read(req_read), .req_chan(req_chan), .req_data(req_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_chan(rsp_chan), .sel_n(sel_n), .rd_wr(rd_wr),
        .chan_b(chan_b), .db_o(db_o), .db_oe(db_oe), .db_i(db_w));
    ddp_dac_model ddp_dac_model_i (.sel_n(sel_n), .rd_wr(rd_wr), .chan_b(chan_b),
        .host_oe(db_oe), .host_d(db_o), .db_line(db_w));
    task conclude;
        begin
            $display("checks %0d errors %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            conclude;
        end
    end
    task check(input [`DDP_DATA_W-1:0] seen, input [`DDP_DATA_W-1:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task xfer(input rd, input ch, input [`DDP_DATA_W-1:0] d);
        integer n;
        begin
            @(posedge clock);
            req_valid <= 1'b1;
            req_read <= rd;
            req_chan <= ch;
            req_data <= d;
            n = 0;
            @(negedge clock);
            while (req_ready !== 1'b1 && n < 40) begin
                @(negedge clock);
                n = n + 1;
            end
            if (n >= 40) err_total = err_total + 1;
            @(posedge clock);
            req_valid <= 1'b0;
        end
    endtask
    task readback(input ch, input [`DDP_DATA_W-1:0] exp);
        integer n;
        begin
            xfer(1'b1, ch, 12'h000);
            n = 0;
            while (rsp_valid !== 1'b1 && n < 20) begin
                @(negedge clock);
                n = n + 1;
            end
            if (n >= 20) err_total = err_total + 1;
            check(rsp_data, exp);
            check({11'h000, rsp_chan}, {11'h000, ch});
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset_zero;
        begin
            readback(1'b0, 12'h000);
            readback(1'b1, 12'h000);
        end
    endtask
    // back-to-back writes to both channels must not bleed into each other
    task t_two_chan;
        begin
            xfer(1'b0, 1'b0, 12'ha5c);
            xfer(1'b0, 1'b1, 12'h3a1);
            readback(1'b0, 12'ha5c);
            readback(1'b1, 12'h3a1);
        end
    endtask
    task t_overwrite;
        begin
            xfer(1'b0, 1'b1, 12'hfff);
            xfer(1'b0, 1'b1, 12'h001);
            readback(1'b1, 12'h001);
            readback(1'b0, 12'ha5c);
        end
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_reset_zero;
        t_two_chan;
        t_overwrite;
        conclude;
    end
endmodule // ddp_host_test
